/* File: common/sgmii_ra_pkg.sv */
package sgmii_ra_pkg;
  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_BASIC   = 12'h000;
  localparam logic [11:0] IDX_CONFIG_TWO    = 12'h014;
  localparam logic [11:0] IDX_LOWSPD  = 12'h16F;
  localparam logic [11:0] IDX_LNKDIS  = 12'h1DF;
  localparam logic [11:0] IDX_STATUS  = 12'h020;
  // Field positions
  localparam int BIT_LOOPBACK = 14;
  localparam int BIT_ISOLATE  = 10;
  localparam int BIT_NEG_EN   = 7;
  localparam int BIT_RATE_AD  = 7;
  localparam int BIT_LNK_DIS  = 0;
  // Reset values
  localparam logic [15:0] RST_BASIC  = 16'h0000;
  localparam logic [15:0] RST_CONFIG_TWO   = 16'h0080;
  localparam logic [15:0] RST_LOWSPD = 16'h0080;
  localparam logic [15:0] RST_LNKDIS = 16'h0000;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Replication counts per port speed
  localparam logic [6:0] REPS_10M   = 7'h64;
  localparam logic [6:0] REPS_100M  = 7'h0A;
  localparam logic [6:0] REPS_1000M = 7'h01;
  // Serial line rate in Mbit/s, independent of port speed
  localparam int LINE_RATE_MBPS = 1250;
  typedef enum logic [1:0] {
    SPD_10   = 2'h0,
    SPD_100  = 2'h1,
    SPD_1000 = 2'h2
  } speed_t;
  // Negotiation states, Gray coded along the path
  typedef enum logic [1:0] {
    NEG_IDLE = 2'b00,
    NEG_SEND = 2'b01,
    NEG_ACK  = 2'b11,
    NEG_DONE = 2'b10
  } neg_state_t;
  // Frame byte on the MAC-side stream
  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } frame_byte_t;
  // Configuration word toward the link partner
  typedef struct packed {
    logic       link;
    logic       ack;
    logic [1:0] rsvd;
    speed_t     speed;
    logic [9:0] fill;
  } cfg_word_t;
endpackage

/* File: src/sgmii_rate_adapt.sv */
`timescale 1ns/1ps
`default_nettype none
module sgmii_rate_adapt
  import sgmii_ra_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic [13:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [13:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Strap and media side status
  input  wire logic        mac_if_strap,
  input  wire logic        media_link,
  input  wire speed_t      media_speed,
  // Frame stream from the media side
  input  wire frame_byte_t in_byte,
  input  wire logic        in_valid,
  output logic             in_ready,
  // Toward the link coder
  output frame_byte_t      out_byte,
  output logic             out_en,
  output logic             out_sof,
  output logic             link_oe,
  // Negotiation words
  output cfg_word_t        cfg_tx,
  output logic             cfg_tx_en,
  input  wire logic        cfg_rx_valid,
  input  wire logic        cfg_rx_ack
);

  logic [15:0] basic_r, config_two_r, lowspd_r, lnkdis_r;
  logic        strap_r, strap_done_r;
  neg_state_t  neg_r;
  frame_byte_t byte_r;
  logic        busy_r, frame_r, sof_r;
  logic [6:0]  rep_r;
  speed_t      fspd_r;
  logic        aw_h_r, w_h_r, bv_r, rv_r;
  logic [11:0] aw_idx_r;
  logic [31:0] w_d_r, rd_r;
  logic [3:0]  w_s_r;
  logic [1:0]  bresp_r, rresp_r;

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    merge = old;
    if (s[0]) merge[7:0] = d[7:0];
    if (s[1]) merge[15:8] = d[15:8];
  endfunction

  // Repetitions per byte for a speed
  function automatic logic [6:0] reps(input speed_t s);
    unique case (s)
      SPD_10:  reps = REPS_10M;
      SPD_100: reps = REPS_100M;
      default: reps = REPS_1000M;
    endcase
  endfunction

  function automatic logic mapped(input logic [11:0] i);
    mapped = (i == IDX_BASIC) || (i == IDX_CONFIG_TWO) || (i == IDX_LOWSPD) ||
             (i == IDX_LNKDIS) || (i == IDX_STATUS);
  endfunction

  logic   neg_en, loopback, isolate, disabled, low_blk, run, acc, last_rep;
  speed_t link_spd;
  assign neg_en   = config_two_r[BIT_NEG_EN];
  assign loopback = basic_r[BIT_LOOPBACK];
  assign isolate  = basic_r[BIT_ISOLATE];   // Deliberately unused by the pins
  assign disabled = lnkdis_r[BIT_LNK_DIS];
  // Loopback and forced mode both take the media speed
  assign link_spd = media_speed;
  // 10 Mbps is held off while rate adaptation is still set
  assign low_blk  = (media_speed == SPD_10) && lowspd_r[BIT_RATE_AD];
  // Pins stay up under isolate; only a low strap or the disable control drops them
  assign link_oe  = strap_r && !disabled;
  assign run      = link_oe && !low_blk && (media_link || loopback) &&
                    (!neg_en || neg_r == NEG_DONE);
  assign last_rep = (rep_r == reps(fspd_r) - 7'h01);
  assign in_ready = run && (!busy_r || last_rep);
  assign acc      = in_valid && in_ready;

  // Strap caught on the first edge after reset release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_r      <= 1'b0;
      strap_done_r <= 1'b0;
    end else if (!strap_done_r) begin
      strap_r      <= mac_if_strap;
      strap_done_r <= 1'b1;
    end
  end

  // In-band negotiation: send config, then acknowledge, then done
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      neg_r <= NEG_IDLE;
    end else if (!neg_en || !link_oe || !(media_link || loopback)) begin
      neg_r <= NEG_IDLE;
    end else begin
      unique case (neg_r)
        NEG_IDLE: neg_r <= NEG_SEND;
        NEG_SEND: if (cfg_rx_valid) neg_r <= NEG_ACK; // Decoded from data timing
        NEG_ACK:  if (cfg_rx_ack) neg_r <= NEG_DONE;
        NEG_DONE: if (fspd_r != link_spd && !busy_r) neg_r <= NEG_SEND;
      endcase
    end
  end

  // Config word carries link state and media speed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_tx    <= '0;
      cfg_tx_en <= 1'b0;
    end else begin
      cfg_tx.link  <= media_link || loopback;
      cfg_tx.ack   <= (neg_r == NEG_ACK);
      cfg_tx.rsvd  <= 2'h0;
      cfg_tx.speed <= link_spd;
      cfg_tx.fill  <= 10'h001;
      cfg_tx_en    <= neg_en && link_oe && (neg_r == NEG_SEND || neg_r == NEG_ACK);
    end
  end

  // Replicator: byte held and counted above the coder, so the coder
  // adds its start marker once; speed is latched per byte so no byte mixes two speeds
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      byte_r <= '0;
      busy_r <= 1'b0;
      rep_r  <= 7'h00;
      fspd_r <= SPD_1000;
    end else if (!link_oe) begin
      busy_r <= 1'b0;
      rep_r  <= 7'h00;
    end else if (acc) begin
      byte_r <= in_byte;
      busy_r <= 1'b1;
      rep_r  <= 7'h00;
      fspd_r <= link_spd;
    end else if (busy_r && last_rep) begin
      busy_r <= 1'b0;
      rep_r  <= 7'h00;
    end else if (busy_r) begin
      rep_r  <= rep_r + 7'h01;
    end else if (!busy_r) begin
      fspd_r <= link_spd;
    end
  end

  // Start marker once per frame
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_r <= 1'b0;
      sof_r   <= 1'b0;
    end else begin
      sof_r <= acc && !frame_r;
      if (!link_oe) frame_r <= 1'b0;
      else if (acc) frame_r <= !in_byte.last;
    end
  end

  // One data stream each way and no forwarded clock toward the coder
  assign out_byte = byte_r;
  // A byte every cycle at any port speed keeps the line rate fixed
  assign out_en   = busy_r;
  assign out_sof  = sof_r;

  // AXI write channel: address and data taken in either order
  assign awready = !aw_h_r && !bv_r;
  assign wready  = !w_h_r && !bv_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_h_r   <= 1'b0;
      w_h_r    <= 1'b0;
      bv_r     <= 1'b0;
      aw_idx_r <= 12'h000;
      w_d_r    <= 32'h0000_0000;
      w_s_r    <= 4'h0;
      bresp_r  <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_h_r   <= 1'b1;
        aw_idx_r <= awaddr[13:2];
      end
      if (wvalid && wready) begin
        w_h_r <= 1'b1;
        w_d_r <= wdata;
        w_s_r <= wstrb;
      end
      if (aw_h_r && w_h_r && !bv_r) begin
        aw_h_r  <= 1'b0;
        w_h_r   <= 1'b0;
        bv_r    <= 1'b1;
        bresp_r <= mapped(aw_idx_r) ? RESP_OKAY : RESP_SLVERR;
      end else if (bv_r && bready) begin
        bv_r <= 1'b0;
      end
    end
  end
  assign bvalid = bv_r;
  assign bresp  = bresp_r;

  // Register file update
  logic wr_go;
  assign wr_go = aw_h_r && w_h_r && !bv_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      basic_r  <= RST_BASIC;
      config_two_r   <= RST_CONFIG_TWO;
      lowspd_r <= RST_LOWSPD;
      lnkdis_r <= RST_LNKDIS;
    end else if (wr_go) begin
      if (aw_idx_r == IDX_BASIC)  basic_r  <= merge(basic_r, w_d_r, w_s_r);
      if (aw_idx_r == IDX_CONFIG_TWO)   config_two_r   <= merge(config_two_r, w_d_r, w_s_r);
      if (aw_idx_r == IDX_LOWSPD) lowspd_r <= merge(lowspd_r, w_d_r, w_s_r);
      if (aw_idx_r == IDX_LNKDIS) lnkdis_r <= merge(lnkdis_r, w_d_r, w_s_r);
    end
  end

  // Read channel: one cycle from address to data
  logic [15:0] status;
  assign status = {10'h000, low_blk, busy_r, strap_r, (neg_r == NEG_DONE), fspd_r};
  assign arready = !rv_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rv_r    <= 1'b0;
      rd_r    <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rv_r    <= 1'b1;
      rresp_r <= mapped(araddr[13:2]) ? RESP_OKAY : RESP_SLVERR;
      unique case (araddr[13:2])
        IDX_BASIC:  rd_r <= {16'h0000, basic_r};
        IDX_CONFIG_TWO:   rd_r <= {16'h0000, config_two_r};
        IDX_LOWSPD: rd_r <= {16'h0000, lowspd_r};
        IDX_LNKDIS: rd_r <= {16'h0000, lnkdis_r};
        IDX_STATUS: rd_r <= {16'h0000, status};
        default:    rd_r <= 32'h0000_0000;
      endcase
    end else if (rv_r && rready) begin
      rv_r <= 1'b0;
    end
  end
  assign rvalid = rv_r;
  assign rdata  = rd_r;
  assign rresp  = rresp_r;

  // Checks
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_REP100: assert property (acc && link_spd == SPD_100 |=>
    (!in_ready)[*8] ##1 !in_ready ##1 in_ready)
    else $error("100M byte not repeated ten times");
  AST_REP10: assert property (busy_r && fspd_r == SPD_10 && rep_r < 7'h63
    |-> !in_ready) else $error("10M byte released early");
  AST_REP10_END: assert property (busy_r && fspd_r == SPD_10 && rep_r == 7'h63 &&
    run |-> in_ready) else $error("10M byte held past 100");
  AST_SOF: assert property (out_sof |-> out_en && rep_r == 7'h00 ##1
    (!out_sof || $past(acc))) else $error("start marker misplaced");
  AST_SOF_ONCE: assert property (acc && frame_r |=> !out_sof)
    else $error("start marker repeated in frame");
  AST_FORCE: assert property (!neg_en && link_oe && media_link && !low_blk &&
    !busy_r |-> in_ready) else $error("forced mode not running");
  AST_NEG_OFF: assert property ($fell(neg_en) |=> neg_r == NEG_IDLE && !cfg_tx_en)
    else $error("negotiation not stopped");
  AST_NEG_GATE: assert property (neg_en && neg_r != NEG_DONE |-> !in_ready)
    else $error("data before negotiation done");
  AST_ISOLATE: assert property (isolate && strap_r && !disabled |-> link_oe)
    else $error("isolate dropped link pins");
  AST_DISABLE: assert property (disabled |-> !link_oe ##1 !out_en)
    else $error("disabled link still driving");
  AST_REP1000: assert property (acc && link_spd == SPD_1000 |=> out_en ##1 !out_en ||
    $past(acc)) else $error("1000M byte repeated");
  AST_LOWBLK: assert property (low_blk |-> !in_ready)
    else $error("10M ran with rate adapt set");

  COV_100: cover property (acc && link_spd == SPD_100 ##10 acc);
  COV_NEG: cover property (neg_r == NEG_SEND ##[1:20] neg_r == NEG_DONE);
  COV_FRAME: cover property (out_sof ##[1:50] acc && in_byte.last);

endmodule // sgmii_rate_adapt
`default_nettype wire

/* File: testbench/mac_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module mac_partner
  import sgmii_ra_pkg::*;
(
  // Clock and reset
  input  wire logic      aclk,
  input  wire logic      aresetn,
  // Negotiation words from the device
  input  wire cfg_word_t cfg_tx,
  input  wire logic      cfg_tx_en,
  // Bench controls: lazy answers, or no answer at all
  input  wire logic      slow,
  input  wire logic      mute,
  // Decoded answers back to the device
  output logic           cfg_rx_valid,
  output logic           cfg_rx_ack
);
  logic [4:0] wait_r;

  // Answer each config word after a delay; no clock is sent back, timing rides on data
  always_ff @(posedge aclk) begin
    if (!aresetn || !cfg_tx_en || mute) begin
      wait_r       <= 5'h00;
      cfg_rx_valid <= 1'b0;
      cfg_rx_ack   <= 1'b0;
    end else if (wait_r != (slow ? 5'h14 : 5'h02)) begin
      wait_r <= wait_r + 5'h01;
    end else begin
      cfg_rx_valid <= 1'b1;
      cfg_rx_ack   <= cfg_tx.ack;
    end
  end
endmodule // mac_partner
`default_nettype wire

/* File: testbench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb
  import sgmii_ra_pkg::*;
;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic        bvalid, arready, rvalid, in_ready, out_en, out_sof, link_oe, cfg_tx_en;
  logic        cfg_rx_valid, cfg_rx_ack, mac_if_strap, media_link, in_valid, slow, mute;
  logic [13:0] awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rsp;
  logic [15:0] rd;
  speed_t      media_speed;
  frame_byte_t in_byte, out_byte;
  cfg_word_t   cfg_tx;
  logic [31:0] seed = 32'h0000_5ff4;
  int          fails, tests_run, sofs, j;
  logic [7:0]  seen[$];

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  sgmii_rate_adapt dut_u (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .mac_if_strap, .media_link, .media_speed, .in_byte,
    .in_valid, .in_ready, .out_byte, .out_en, .out_sof, .link_oe, .cfg_tx, .cfg_tx_en,
    .cfg_rx_valid, .cfg_rx_ack);
  mac_partner far_u (.aclk, .aresetn, .cfg_tx, .cfg_tx_en, .slow, .mute, .cfg_rx_valid,
    .cfg_rx_ack);

  // Link monitor samples mid-cycle, where registered outputs have settled
  always @(negedge aclk) begin
    if (out_en === 1'b1) seen.push_back(out_byte.data);
    if (out_sof === 1'b1) sofs++;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic int reps_of(speed_t s);
    return (s == SPD_10) ? 100 : (s == SPD_100) ? 10 : 1;
  endfunction

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic give_verdict();
    $display("Counts: %0d checks, %0d mismatches", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // A wait that ran out is a mismatch and ends the run
  task automatic tmo(input int n, input int lim);
    if (n >= lim) begin
      fails++;
      $display("ERROR handshake expected within %0d seen none", lim);
      give_verdict();
    end
  endtask

  task automatic axi_wr(input logic [11:0] idx, input logic [15:0] d);
    int n;
    logic ap, wp, at, wt;
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    ap = 1'b1;
    wp = 1'b1;
    // Each half released at the edge that takes it, in whichever order
    for (n = 0; n < 50 && (ap || wp); n++) begin
      @(negedge aclk);
      at = ap && awready === 1'b1;
      wt = wp && wready === 1'b1;
      @(posedge aclk);
      if (at) awvalid <= 1'b0;
      if (wt) wvalid <= 1'b0;
      ap = ap && !at;
      wp = wp && !wt;
    end
    tmo(n, 50);
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin @(negedge aclk); if (bvalid === 1'b1) break; end
    tmo(n, 50);
    rsp = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [11:0] idx);
    int n;
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin @(negedge aclk); if (arready === 1'b1) break; end
    tmo(n, 50);
    @(posedge aclk);
    arvalid <= 1'b0;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin @(negedge aclk); if (rvalid === 1'b1) break; end
    tmo(n, 50);
    rd = rdata[15:0];
    rsp = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask

  // Random frame of n bytes; every byte must appear r times, one start marker
  task automatic send_frame(input int n, input int r);
    logic [7:0] exp[$];
    int i, k;
    seen.delete();
    sofs = 0;
    for (i = 0; i < n; i++) begin
      v = xs();
      exp.push_back(v[7:0]);
      @(posedge aclk);
      in_byte <= '{data: v[7:0], last: (i == n - 1)};
      in_valid <= 1'b1;
      for (k = 0; k < 400; k++) begin @(negedge aclk); if (in_ready === 1'b1) break; end
      tmo(k, 400);
    end
    @(posedge aclk);
    in_valid <= 1'b0;
    for (k = 0; k < n * r + 50 && seen.size() < n * r; k++) @(posedge aclk);
    repeat (3) @(posedge aclk);
    chk("out count", seen.size(), n * r);
    for (i = 0; i < seen.size() && i < n * r; i++) chk("out byte", seen[i], exp[i / r]);
    chk("sof count", sofs, 1);
  endtask

  // Hold a byte offered and expect it still refused after 30 cycles
  task automatic refused();
    @(posedge aclk);
    in_valid <= 1'b1;
    repeat (30) @(negedge aclk);
    chk("in_ready", in_ready, 0);
    @(posedge aclk);
    in_valid <= 1'b0;
  endtask

  task automatic do_reset(input logic strap);
    @(posedge aclk);
    aresetn <= 1'b0;
    mac_if_strap <= strap;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk("link_oe", link_oe, strap);
  endtask

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, in_valid, slow} = '0;
    {awaddr, araddr, wdata, in_byte} = '0;
    {wstrb, mac_if_strap, media_link, mute} = 7'h7f;
    media_speed = SPD_1000;
    fails = 0;
    tests_run = 0;
    sofs = 0;
    do_reset(1'b1);
    axi_rd(IDX_BASIC);
    chk("basic_control", rd, RST_BASIC);
    chk("rresp", rsp, RESP_OKAY);
    axi_rd(IDX_CONFIG_TWO);
    chk("config_two", rd, RST_CONFIG_TWO);
    axi_rd(IDX_LOWSPD);
    chk("low_speed_serial_config", rd, RST_LOWSPD);
    axi_rd(IDX_LNKDIS);
    chk("serial_link_disable", rd, RST_LNKDIS);
    axi_rd(12'h001);
    chk("unmapped rresp", rsp, RESP_SLVERR);
    axi_wr(12'h002, 16'h1234);
    chk("unmapped bresp", rsp, RESP_SLVERR);
    $display("test registers done");
    refused();
    chk("cfg_tx_en", cfg_tx_en, 1);
    chk("cfg_tx speed", cfg_tx.speed, SPD_1000);
    chk("cfg_tx link", cfg_tx.link, 1);
    mute <= 1'b0;
    send_frame(5, 1);
    axi_rd(IDX_STATUS);
    chk("status", rd, 16'h000e);
    media_speed <= SPD_100;
    slow <= 1'b1;
    send_frame(4, 10);
    $display("test negotiated speeds done");
    media_speed <= SPD_10;
    refused();
    axi_wr(IDX_LOWSPD, 16'h0000);
    chk("bresp", rsp, RESP_OKAY);
    send_frame(2, 100);
    $display("test low speed done");
    // Partner goes silent; forced speed must follow media speed alone
    mute <= 1'b1;
    axi_wr(IDX_CONFIG_TWO, 16'h0000);
    for (j = 0; j < 3; j++) begin
      v = xs();
      media_speed <= speed_t'(v[1:0] % 2'h3);
      @(posedge aclk);
      send_frame(2, reps_of(media_speed));
    end
    $display("test forced speed done");
    media_link <= 1'b0;
    axi_wr(IDX_BASIC, 16'h4400);
    axi_rd(IDX_BASIC);
    chk("basic_control rw", rd, 16'h4400);
    chk("link_oe isolate", link_oe, 1);
    media_speed <= SPD_100;
    send_frame(3, 10);
    // Loopback again with negotiation back on and the partner answering
    mute <= 1'b0;
    axi_wr(IDX_CONFIG_TWO, RST_CONFIG_TWO);
    send_frame(2, 10);
    axi_wr(IDX_LNKDIS, 16'h0001);
    @(negedge aclk);
    chk("link_oe disabled", link_oe, 0);
    axi_wr(IDX_LNKDIS, 16'h0000);
    @(negedge aclk);
    chk("link_oe enabled", link_oe, 1);
    $display("test loopback and pins done");
    do_reset(1'b0);
    $display("test strap done");
    give_verdict();
  end
endmodule // tb
`default_nettype wire
